//--- src/timer_pkg.sv
package timer_pkg;
   // Register word offsets, byte addresses
   localparam logic [3:0] OFS_CNT0 = 4'h0;
   localparam logic [3:0] OFS_CNT1 = 4'h4;
   localparam logic [3:0] OFS_CNT2 = 4'h8;
   localparam logic [3:0] OFS_CTRL = 4'hc;
   localparam logic [1:0] IDX_CTRL = 2'h3;
   // Control byte fields
   localparam int SEL_MSB = 7;
   localparam int SEL_LSB = 6;
   localparam int ACC_MSB = 5;
   localparam int ACC_LSB = 4;
   localparam int MODE_MSB = 3;
   localparam int MODE_LSB = 1;
   localparam int BCD_BIT = 0;
   localparam logic [1:0] SEL_ILLEGAL = 2'h3;
   localparam logic [1:0] ACC_LATCH = 2'h0;
   localparam logic [1:0] ACC_LSB_ONLY = 2'h1;
   localparam logic [1:0] ACC_MSB_ONLY = 2'h2;
   localparam logic [1:0] ACC_BOTH = 2'h3;
   // Counter clock of both pacer channels, in hertz
   localparam int PACER_CLK_HZ = 10_000_000;
   localparam int NUM_CHAN = 3;

   typedef enum logic [2:0] {
      MODE_TC_EVENT,
      MODE_ONE_SHOT,
      MODE_RATE,
      MODE_SQUARE,
      MODE_SW_STROBE,
      MODE_HW_STROBE
   } mode_e;

   typedef struct packed {
      mode_e mode;
      logic [1:0] access;
      logic bcd;
      logic [15:0] count;
      logic [15:0] initial_cnt;
      logic [15:0] hold;
      logic [7:0] lsb_buf;
      logic holding;
      logic wr_msb;
      logic rd_msb;
      logic loaded;
      logic have;
      logic running;
      logic trig;
      logic out;
      logic gate_q;
      logic clk_q;
   } chan_s;

   typedef struct packed {
      chan_s [NUM_CHAN-1:0] ch;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } timer_s;
endpackage

//--- src/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int W = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] pin,
   output logic [W-1:0] synced
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_reg <= '0;
         synced <= '0;
      end
      else
      begin
         meta_reg <= pin;
         synced <= meta_reg;
      end
   end
endmodule
`default_nettype wire

//--- src/count_step.sv
`timescale 1ns/1ps
`default_nettype none
module count_step (
   input wire logic [15:0] value,
   input wire logic bcd,
   input wire logic [1:0] step,
   output logic [15:0] result
);
   // Decimal mode borrows per decade so the count wraps 0000 to 9999
   always_comb
   begin
      logic [4:0] d;
      logic [4:0] sub;
      d = '0;
      sub = {3'h0, step};
      result = value - {14'h0, step};
      if (bcd)
      begin
         for (int k = 0; k < 4; k++)
         begin
            d = {1'b0, value[4*k +: 4]} - sub;
            if (d[4])
            begin
               d = 5'(d + 5'd10);
               sub = 5'd1;
            end
            else
               sub = 5'd0;
            result[4*k +: 4] = d[3:0];
         end
      end
   end
endmodule
`default_nettype wire

//--- src/interval_timer.sv
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Three independent 16-bit down-counters, each set to one of six modes.
// - Channel data words at 0x0, 0x4, 0x8; control byte at 0xc.
// - Bits 7:6 pick the channel; value 3 is ignored.
// - Bits 5:4: latch, low byte, high byte, or low then high.
// - Bits 3:1 pick the mode; top bit ignored for modes 2 and 3.
// - Bit 0 picks 16-bit binary or four-decade decimal counting.
// - Mode 0: output low from setup, high at zero, count keeps running.
// - Mode 0: first byte of a new count halts, second byte restarts.
// - Mode 1: gate rise starts a full low pulse, output high at zero.
// - Mode 1: new count waits for next trigger; reading never disturbs.
// - Mode 2: divide by N, one low tick per period, reload between.
// - Mode 2: low gate forces high, gate rise restarts; idle until loaded.
// - Mode 3: step by two, toggle and reload at zero; odd N split.
// - Mode 4: high after setup, count on load, one low tick, gate pauses.
// - Mode 4: a rewritten count is taken on the next counter clock.
// - Mode 5: gate rise starts count, one low tick, retriggerable.
// - Channel 0 counts the 10 MHz pacer clock.
// - Channel 1 counts the same 10 MHz pacer clock.
module interval_timer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pacer_clk,
   input wire logic aux_clk,
   input wire logic [2:0] gate,
   output logic [2:0] timer_out
);
   timer_pkg::timer_s state_reg;
   timer_pkg::timer_s state_next;
   logic [5:0] pins_s;
   logic [2:0] clk_s;
   logic [2:0] gate_s;
   logic [2:0] tick;
   logic [15:0] dec [3];
   logic [1:0] step [3];
   logic [7:0] rd_byte [3];
   logic mapped;
   logic [1:0] idx;
   logic first_acc;
   logic wr_done;
   logic rd_done;
   logic [7:0] d;
   logic [1:0] sel;
   logic [1:0] acc;
   logic [2:0] mode_raw;

   // Counter clocks and gates are asynchronous pins
   pin_sync #(.W(6)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin({aux_clk, pacer_clk, pacer_clk, gate}),
      .synced(pins_s)
   );
   assign gate_s = pins_s[2:0];
   assign clk_s = pins_s[5:3];

   assign idx = paddr[3:2];
   assign mapped = (paddr[1:0] == 2'h0) && (paddr[7:4] == 4'h0);
   assign first_acc = psel & penable & ~state_reg.pready;
   assign wr_done = psel & penable & state_reg.pready & mapped & pwrite;
   assign rd_done = psel & penable & state_reg.pready & mapped & ~pwrite;
   assign d = pwdata[7:0];
   assign sel = pwdata[timer_pkg::SEL_MSB:timer_pkg::SEL_LSB];
   assign acc = pwdata[timer_pkg::ACC_MSB:timer_pkg::ACC_LSB];
   assign mode_raw = pwdata[timer_pkg::MODE_MSB:timer_pkg::MODE_LSB];

   genvar g;
   generate
      for (g = 0; g < timer_pkg::NUM_CHAN; g++)
      begin : g_chan
         logic [15:0] src;
         // Counting steps on the falling edge of the counter clock
         assign tick[g] = state_reg.ch[g].clk_q & ~clk_s[g];
         assign step[g] = (state_reg.ch[g].mode == timer_pkg::MODE_SQUARE) ?
            (state_reg.ch[g].count[0] ? (state_reg.ch[g].out ? 2'h1 : 2'h3) : 2'h2) : 2'h1;
         count_step u_step (
            .value(state_reg.ch[g].count),
            .bcd(state_reg.ch[g].bcd),
            .step(step[g]),
            .result(dec[g])
         );
         assign src = state_reg.ch[g].holding ? state_reg.ch[g].hold : state_reg.ch[g].count;
         assign rd_byte[g] = ((state_reg.ch[g].access == timer_pkg::ACC_MSB_ONLY) ||
            ((state_reg.ch[g].access == timer_pkg::ACC_BOTH) && state_reg.ch[g].rd_msb)) ?
            src[15:8] : src[7:0];
         assign timer_out[g] = state_reg.ch[g].out;
      end
   endgenerate

   assign prdata = state_reg.prdata;
   assign pready = state_reg.pready;
   assign pslverr = state_reg.pslverr;

   always_comb
   begin
      timer_pkg::chan_s c;
      logic commit;
      logic start;
      c = '0;
      commit = 1'b0;
      start = 1'b0;
      state_next = state_reg;
      // One wait state: the word is answered one cycle into the access phase
      state_next.pready = first_acc;
      state_next.pslverr = first_acc & ~mapped;
      state_next.prdata = '0;
      if (first_acc && mapped && !pwrite && idx != timer_pkg::IDX_CTRL)
         state_next.prdata = {24'h0, rd_byte[idx]};
      for (int i = 0; i < timer_pkg::NUM_CHAN; i++)
      begin
         c = state_reg.ch[i];
         c.clk_q = clk_s[i];
         c.gate_q = gate_s[i];
         commit = 1'b0;
         start = 1'b0;
         if (tick[i])
         begin
            case (c.mode)
               timer_pkg::MODE_TC_EVENT:
                  if (c.loaded)
                  begin
                     c.count = c.initial_cnt;
                     c.loaded = 1'b0;
                     c.running = 1'b1;
                  end
                  else if (c.running)
                  begin
                     c.count = dec[i];
                     if (c.count == 16'h0000)
                        c.out = 1'b1;
                  end
               timer_pkg::MODE_ONE_SHOT:
               begin
                  if (c.trig && c.have)
                  begin
                     c.count = c.initial_cnt;
                     c.out = 1'b0;
                     c.running = 1'b1;
                  end
                  else if (c.running)
                  begin
                     c.count = dec[i];
                     if (c.count == 16'h0000)
                     begin
                        c.out = 1'b1;
                        c.running = 1'b0;
                     end
                  end
                  c.trig = 1'b0;
               end
               timer_pkg::MODE_RATE, timer_pkg::MODE_SQUARE:
               begin
                  start = c.have && (c.trig || (c.loaded && !c.running)) && gate_s[i];
                  if (start)
                  begin
                     c.count = c.initial_cnt;
                     c.out = 1'b1;
                     c.running = 1'b1;
                     c.loaded = 1'b0;
                  end
                  else if (c.running && gate_s[i] && c.mode == timer_pkg::MODE_RATE)
                  begin
                     if (!c.out)
                     begin
                        c.count = c.initial_cnt;
                        c.out = 1'b1;
                        c.loaded = 1'b0;
                     end
                     else
                     begin
                        c.count = dec[i];
                        if (c.count == 16'h0001)
                           c.out = 1'b0;
                     end
                  end
                  else if (c.running && gate_s[i])
                  begin
                     if (c.count <= {14'h0, step[i]})
                     begin
                        c.count = c.initial_cnt;
                        c.out = ~c.out;
                        c.loaded = 1'b0;
                     end
                     else
                        c.count = dec[i];
                  end
                  c.trig = 1'b0;
               end
               timer_pkg::MODE_SW_STROBE:
               begin
                  c.out = 1'b1;
                  if (c.loaded)
                  begin
                     c.count = c.initial_cnt;
                     c.loaded = 1'b0;
                     c.running = 1'b1;
                  end
                  else if (c.running && gate_s[i])
                  begin
                     c.count = dec[i];
                     if (c.count == 16'h0000)
                     begin
                        c.out = 1'b0;
                        c.running = 1'b0;
                     end
                  end
               end
               timer_pkg::MODE_HW_STROBE:
               begin
                  c.out = 1'b1;
                  if (c.trig && c.have)
                  begin
                     c.count = c.initial_cnt;
                     c.running = 1'b1;
                  end
                  else if (c.running)
                  begin
                     c.count = dec[i];
                     if (c.count == 16'h0000)
                     begin
                        c.out = 1'b0;
                        c.running = 1'b0;
                     end
                  end
                  c.trig = 1'b0;
               end
               default:
                  c.running = 1'b0;
            endcase
         end
         // A gate edge in the same cycle as a consumed trigger is kept
         if (gate_s[i] && !state_reg.ch[i].gate_q)
            c.trig = 1'b1;
         if ((c.mode == timer_pkg::MODE_RATE || c.mode == timer_pkg::MODE_SQUARE) && !gate_s[i])
            c.out = 1'b1;
         if (wr_done && idx == timer_pkg::IDX_CTRL && sel != timer_pkg::SEL_ILLEGAL && sel == 2'(i))
         begin
            if (acc == timer_pkg::ACC_LATCH)
            begin
               // A second latch before the read is ignored, as the first value is still owed
               if (!c.holding)
               begin
                  c.hold = state_reg.ch[i].count;
                  c.holding = 1'b1;
                  c.rd_msb = 1'b0;
               end
            end
            else
            begin
               c.mode = timer_pkg::mode_e'(mode_raw[1] ? {1'b0, mode_raw[1:0]} : mode_raw);
               c.access = acc;
               c.bcd = pwdata[timer_pkg::BCD_BIT];
               c.out = (c.mode != timer_pkg::MODE_TC_EVENT);
               c.running = 1'b0;
               c.loaded = 1'b0;
               c.have = 1'b0;
               c.trig = 1'b0;
               c.wr_msb = 1'b0;
               c.rd_msb = 1'b0;
               c.holding = 1'b0;
            end
         end
         if (wr_done && idx == 2'(i))
         begin
            case (c.access)
               timer_pkg::ACC_LSB_ONLY:
               begin
                  c.initial_cnt = {8'h00, d};
                  commit = 1'b1;
               end
               timer_pkg::ACC_MSB_ONLY:
               begin
                  c.initial_cnt = {d, 8'h00};
                  commit = 1'b1;
               end
               timer_pkg::ACC_BOTH:
                  if (!c.wr_msb)
                  begin
                     c.lsb_buf = d;
                     c.wr_msb = 1'b1;
                     if (c.mode == timer_pkg::MODE_TC_EVENT)
                        c.running = 1'b0;
                  end
                  else
                  begin
                     c.initial_cnt = {d, c.lsb_buf};
                     c.wr_msb = 1'b0;
                     commit = 1'b1;
                  end
               default:
                  commit = 1'b0;
            endcase
            if (commit)
            begin
               c.loaded = 1'b1;
               c.have = 1'b1;
               if (c.mode == timer_pkg::MODE_TC_EVENT)
               begin
                  c.out = 1'b0;
                  c.running = 1'b0;
               end
            end
         end
         if (rd_done && idx == 2'(i))
         begin
            if (c.access == timer_pkg::ACC_BOTH && !c.rd_msb)
               c.rd_msb = 1'b1;
            else
            begin
               c.rd_msb = 1'b0;
               c.holding = 1'b0;
            end
         end
         state_next.ch[i] = c;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_reg <= '0;
      else
         state_reg <= state_next;
   end

   a_apb_wait_one: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready) |=> pready) else $error("access phase not answered after one wait");
   a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
      (pready && pslverr) |-> (paddr[1:0] != 2'h0 || paddr[7:4] != 4'h0)) else $error("error on mapped address");
   a_illegal_select: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_done && idx == timer_pkg::IDX_CTRL && sel == timer_pkg::SEL_ILLEGAL)
      |=> $stable(state_reg.ch[0].mode) && $stable(state_reg.ch[1].mode) && $stable(state_reg.ch[2].mode))
      else $error("illegal select changed a channel");
   a_mode0_low: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_done && idx == timer_pkg::IDX_CTRL && sel == 2'h0 && acc != timer_pkg::ACC_LATCH && mode_raw == 3'h0)
      |=> !timer_out[0]) else $error("mode 0 output not low after setup");
   a_mode4_high: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_done && idx == timer_pkg::IDX_CTRL && sel == 2'h2 && acc != timer_pkg::ACC_LATCH && mode_raw == 3'h4)
      |=> timer_out[2] ##1 timer_out[2]) else $error("mode 4 output not high after setup");
   a_halt_first_byte: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_done && idx == 2'h0 && state_reg.ch[0].access == timer_pkg::ACC_BOTH && !state_reg.ch[0].wr_msb &&
      state_reg.ch[0].mode == timer_pkg::MODE_TC_EVENT) |=> !state_reg.ch[0].running)
      else $error("first byte did not halt mode 0");
   a_latch_frozen: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg.ch[0].holding && !(wr_done || rd_done)) |=> $stable(state_reg.ch[0].hold))
      else $error("latched value changed");
   a_rate_gate_low: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg.ch[2].mode == timer_pkg::MODE_RATE && !gate_s[2] && !wr_done) |=> timer_out[2])
      else $error("mode 2 output low with gate low");
   a_shot_end: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg.ch[2].mode == timer_pkg::MODE_ONE_SHOT && tick[2] && state_reg.ch[2].running &&
      !state_reg.ch[2].trig && dec[2] == 16'h0000 && !wr_done) |=> timer_out[2]) else $error("one-shot did not end");
endmodule
`default_nettype wire

//--- testbench/counter_clock_source.sv
`timescale 1ns/1ps
`default_nettype none
module counter_clock_source (
   output logic pacer_clk,
   output logic aux_clk
);
   // Oscillators run free; offsets keep their edges away from pclk edges
   initial
   begin
      pacer_clk = 1'b0;
      #7;
      forever #50 pacer_clk = ~pacer_clk;
   end
   // Slow enough that one tick leaves room for two register writes
   initial
   begin
      aux_clk = 1'b1;
      #13;
      forever #320 aux_clk = ~aux_clk;
   end
endmodule
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   typedef struct packed {logic err; logic [7:0] msk; logic [7:0] dat;} note_s;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pacer_clk, aux_clk;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [2:0] gate, timer_out;
   int num_errors, checked;
   note_s exp_q[$];
   logic [2:0] mode_t [7] = '{3'b110, 3'b011, 3'b111, 3'b100, 3'b001, 3'b101, 3'b010};
   int cnt_t [7] = '{3, 5, 4, 2, 3, 2, 3};
   int skip_t [7] = '{1, 2, 2, 0, 0, 0, 1};
   int len_t [7] = '{9, 10, 8, 6, 8, 6, 6};
   int high_t [7] = '{6, 6, 4, 5, 5, 5, 6};
   logic gate_t [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

   interval_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pacer_clk(pacer_clk), .aux_clk(aux_clk), .gate(gate), .timer_out(timer_out));
   counter_clock_source src_u (.pacer_clk(pacer_clk), .aux_clk(aux_clk));

   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic err,
                      input logic [7:0] msk, input logic [7:0] dat, output logic [7:0] q);
      int n;
      exp_q.push_back({err, msk, dat});
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      q = prdata[7:0];
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         num_errors++;
         report_and_stop();
      end
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      apb(1'b1, a, d, !(a inside {8'h00, 8'h04, 8'h08, 8'h0c}), 8'h00, 8'h00, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] q;
      logic err;
      err = !(a inside {8'h00, 8'h04, 8'h08, 8'h0c});
      apb(1'b0, a, 8'h00, err, err ? 8'h00 : 8'hff, e, q);
   endtask

   task automatic rq(input logic [7:0] a, output logic [7:0] q);
      apb(1'b0, a, 8'h00, 1'b0, 8'h00, 8'h00, q);
   endtask

   task automatic ctrl(input logic [1:0] s, input logic [1:0] acc, input logic [2:0] m, input logic b);
      wr(8'h0c, {s, acc, m, b});
   endtask

   // Second byte lands well before the next tick, so the first tick always loads
   task automatic load(input logic [7:0] lo, input logic [7:0] hi);
      @(negedge aux_clk);
      repeat (2) @(posedge pclk);
      wr(8'h08, lo);
      wr(8'h08, hi);
   endtask

   task automatic out_is(input logic e);
      repeat (2) @(posedge pclk);
      check({32'h0, timer_out[2]}, {32'h0, e});
   endtask

   // Samples the output between ticks, after the synchroniser delay has passed
   task automatic falls(input int n, output int h);
      h = 0;
      repeat (n)
      begin
         @(negedge aux_clk);
         repeat (6) @(posedge pclk);
         if (timer_out[2] === 1'b1)
            h++;
      end
   endtask

   always @(posedge pclk)
   begin
      note_s e;
      if (psel && penable && pready === 1'b1)
      begin
         e = exp_q.pop_front();
         check({pslverr, pwrite ? 32'h0 : prdata & {24'hffffff, e.msk}},
            {e.err, 24'h0, e.dat & e.msk});
      end
   end

   initial
   begin
      repeat (100000) @(posedge pclk);
      num_errors++;
      report_and_stop();
   end

   initial
   begin
      int h;
      logic [7:0] a;
      logic [15:0] v;
      num_errors = 0;
      checked = 0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      gate = 3'h0;
      presetn = 1'b0;
      v = 16'($urandom(70751));
      repeat (12) @(posedge pclk);
      check({30'h0, timer_out}, 33'h0);
      presetn <= 1'b1;
      @(posedge pclk);
      a = {4'($urandom_range(15, 1)), 4'($urandom)};
      wr(a, 8'($urandom));
      rd(a, 8'h00);
      rd(8'h06, 8'h00);
      rd(8'h0c, 8'h00);
      ctrl(2'd2, 2'd3, 3'd0, 1'b0);
      out_is(1'b0);
      load(8'h00, 8'h01);
      falls(2, h);
      wr(8'h08, 8'h03);
      falls(3, h);
      check(33'(h), 33'h0);
      wr(8'h08, 8'h00);
      ctrl(2'd3, 2'd3, 3'd2, 1'b0);
      falls(3, h);
      check(33'(h), 33'h0);
      falls(3, h);
      check(33'(h), 33'h3);
      ctrl(2'd2, 2'd0, 3'd0, 1'b0);
      rd(8'h08, 8'hfe);
      rd(8'h08, 8'hff);
      for (int b = 0; b < 2; b++)
      begin
         ctrl(2'd2, 2'd3, 3'd0, b[0]);
         load(8'h00, 8'h01);
         falls(3, h);
         ctrl(2'd2, 2'd0, 3'd0, 1'b0);
         rd(8'h08, b ? 8'h98 : 8'hfe);
         rd(8'h08, 8'h00);
      end
      for (int c = 1; c < 4; c++)
      begin
         v = 16'($urandom);
         ctrl(2'd2, c[1:0], 3'd4, 1'b0);
         if (c != 2)
            wr(8'h08, v[7:0]);
         if (c != 1)
            wr(8'h08, v[15:8]);
         falls(3, h);
         check(33'(h), 33'h3);
         ctrl(2'd2, 2'd0, 3'd0, 1'b0);
         if (c != 2)
            rd(8'h08, v[7:0]);
         if (c != 1)
            rd(8'h08, v[15:8]);
      end
      for (int i = 0; i < 7; i++)
      begin
         gate[2] <= gate_t[i];
         ctrl(2'd2, 2'd3, mode_t[i], 1'b0);
         if (mode_t[i][1:0] == 2'b10 || mode_t[i] == 3'b100)
            out_is(1'b1);
         load(8'(cnt_t[i]), 8'h00);
         if (mode_t[i][1:0] == 2'b01)
            gate[2] <= 1'b1;
         else if (mode_t[i][1] && gate_t[i])
         begin
            // Foreign counter clock: a gate pulse right after the count keeps the start in step
            gate[2] <= 1'b0;
            @(posedge pclk);
            gate[2] <= 1'b1;
         end
         falls(skip_t[i], h);
         falls(len_t[i], h);
         check(33'(h), 33'(high_t[i]));
      end
      for (int c = 0; c < 2; c++)
      begin
         ctrl(c[1:0], 2'd3, 3'd0, 1'b0);
         wr(8'(c * 4), 8'h00);
         wr(8'(c * 4), 8'h10);
         repeat (250) @(posedge pclk);
         check({32'h0, timer_out[c]}, 33'h0);
         ctrl(c[1:0], 2'd0, 3'd0, 1'b0);
         rq(8'(c * 4), v[7:0]);
         rq(8'(c * 4), v[15:8]);
         check({32'h0, v >= 16'h0f99 && v <= 16'h0f9e}, 33'h1);
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
